// *** rtl/basseq_pkg.sv ***
package basseq_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS    = 8'h04;
  localparam logic [7:0]  RESULT0_OFS   = 8'h10;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  // ctrl fields: [2:0] function, [4:3] averaging, [6:5] resolution, [7] start
  localparam int          FN_LSB        = 0;
  localparam int          AVG_LSB       = 3;
  localparam int          RES_LSB       = 5;
  localparam int          START_BIT     = 7;
  // ---------------------------------------------------------------
  // timing, 200 MHz clock
  // ---------------------------------------------------------------
  localparam int          CLK_MHZ       = 200;
  localparam int          FIXED_NS      = 2625;   // single reading overhead
  localparam int          SCAN_NS       = 7500;   // port scan overhead
  localparam int          PER_NS        = 4400;   // per conversion overhead
  localparam int          REF_NS        = 1000;   // reference delay
  localparam int          CONV_DIV      = 50;     // conversion clock period in cycles
  localparam logic [15:0] FIXED_CYC     = 16'((FIXED_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SCAN_CYC      = 16'((SCAN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] PER_CYC       = 16'((PER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] REF_CYC       = 16'((REF_NS * CLK_MHZ + 999) / 1000);
  // functions selected in ctrl
  typedef enum logic [2:0] {
    BASSEQ_FN_BAT1 = 3'h0,
    BASSEQ_FN_BAT2 = 3'h1,
    BASSEQ_FN_AUXILIARY_INPUT_ONE = 3'h2,
    BASSEQ_FN_AUXILIARY_INPUT_TWO = 3'h3,
    BASSEQ_FN_SCAN = 3'h4
  } basseq_fn_t;
endpackage

// *** rtl/basseq_conv_if.sv ***
interface basseq_conv_if;
  logic        start;
  logic [1:0]  chan;
  logic [15:0] conv_cyc;
  logic        done;
  logic [11:0] code;
  modport seq (output start, output chan, output conv_cyc, input done, input code);
  modport conv (input start, input chan, input conv_cyc, output done, output code);
endinterface

// *** rtl/basseq_conv.sv ***
module basseq_conv
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // sequencer side
  basseq_conv_if.conv       cv,
  // analog front end
  input  wire logic [11:0]  sample_code
);
  logic [15:0] cnt_r;
  logic        busy_r;
  logic [11:0] code_r;
  logic        done_r;

  // one conversion: counts the requested cycles, then captures the code
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      code_r <= 12'h000;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (cv.start && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r  <= cv.conv_cyc;
      end
      else if (busy_r)
      begin
        if (cnt_r <= 16'h0001)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          code_r <= sample_code;
        end
        else
          cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  assign cv.done = done_r;
  assign cv.code = code_r;
endmodule

// *** rtl/basseq_top.sv ***
// Contract
// - battery code is input voltage over four
// - divider on only while sampling battery
// - single reading time follows averaging formula
// - two auxiliary inputs read like battery
// - port scan converts both batteries, both auxiliaries
// - scan updates all four result registers
// - scan time follows four-conversion formula
//
// Chosen here: the AHB-Lite register port and the address map.
module basseq_top
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // analog front end
  input  wire logic [11:0]  sample_code,
  output logic              divider_on,
  output logic      [1:0]   mux_sel
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_WAIT = 4'b1000
  } basseq_st_t;

  basseq_st_t  st_r;
  logic [7:0]  ctrl_r;
  logic [11:0] res_r [4];
  logic        done_r;
  logic        busy_r;
  logic [15:0] pre_r;
  logic [1:0]  chan_r;
  logic [4:0]  avg_left_r;
  logic        start_r;
  logic        wr_ph_r;
  logic [7:0]  adr_r;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;

  basseq_conv_if cif ();

  // averaging count 1/4/8/16 and resolution 8/10/12 bits
  function automatic logic [4:0] avg_n(input logic [1:0] f);
    unique case (f)
      2'h0: avg_n = 5'h01;
      2'h1: avg_n = 5'h04;
      2'h2: avg_n = 5'h08;
      2'h3: avg_n = 5'h10;
    endcase
  endfunction

  function automatic logic [15:0] conv_len(input logic [1:0] r);
    logic [3:0] bits;
    bits = (r == 2'h0) ? 4'hC : ((r == 2'h1) ? 4'h8 : 4'hA);
    // start and done handshake cycles count toward each conversion
    conv_len = 16'(bits * basseq_pkg::CONV_DIV) + basseq_pkg::PER_CYC - 16'h0002;
  endfunction

  wire logic       scan   = (ctrl_r[2:0] == basseq_pkg::BASSEQ_FN_SCAN);
  wire logic [1:0] avg_f  = ctrl_r[basseq_pkg::AVG_LSB +: 2];
  wire logic [1:0] res_f  = ctrl_r[basseq_pkg::RES_LSB +: 2];

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  wire logic take = hsel && hready && htrans[1];

  // capture address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_r <= 1'b0;
      adr_r   <= 8'h00;
    end
    else if (hready)
    begin
      wr_ph_r <= take && hwrite;
      adr_r   <= haddr;
    end
  end

  // control write; start bit self-clears into a one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r  <= basseq_pkg::CTRL_RST;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      if (wr_ph_r && adr_r == basseq_pkg::CTRL_OFS)
      begin
        ctrl_r  <= {1'b0, hwdata[6:0]};
        start_r <= hwdata[basseq_pkg::START_BIT] && !busy_r;
      end
    end
  end

  // control value as it stands after a write now in its data phase
  wire logic [7:0] ctrl_fwd = (wr_ph_r && adr_r == basseq_pkg::CTRL_OFS) ?
                              {1'b0, hwdata[6:0]} : ctrl_r;

  // read mux on the address phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr == basseq_pkg::CTRL_OFS)
      rd_mux = {24'h00_0000, ctrl_fwd};
    else if (haddr == basseq_pkg::STATUS_OFS)
      rd_mux = {30'h0000_0000, busy_r, done_r};
    else if (haddr[7:4] == basseq_pkg::RESULT0_OFS[7:4] && haddr[1:0] == 2'h0)
      rd_mux = {20'h0_0000, res_r[haddr[3:2]]};
  end

  // read data taken at the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (hready)
      hrdata_r <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r       <= ST_IDLE;
      pre_r      <= 16'h0000;
      chan_r     <= 2'h0;
      avg_left_r <= 4'h0;
      busy_r     <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
          if (start_r)
          begin
            busy_r     <= 1'b1;
            chan_r     <= scan ? 2'h0 : ctrl_r[1:0];
            pre_r      <= (scan ? basseq_pkg::SCAN_CYC : basseq_pkg::FIXED_CYC)
                          + basseq_pkg::REF_CYC;
            avg_left_r <= avg_n(avg_f);
            st_r       <= ST_PRE;
          end
        ST_PRE:
          if (pre_r <= 16'h0001)
            st_r <= ST_CONV;
          else
            pre_r <= pre_r - 16'h0001;
        ST_CONV:
          st_r <= ST_WAIT;
        ST_WAIT:
          if (cif.done)
          begin
            if (avg_left_r > 5'h01)
            begin
              avg_left_r <= avg_left_r - 5'h01;
              st_r       <= ST_CONV;
            end
            else if (scan && chan_r != 2'h3)
            begin
              chan_r     <= chan_r + 2'h1;
              avg_left_r <= avg_n(avg_f);
              st_r       <= ST_CONV;
            end
            else
            begin
              busy_r <= 1'b0;
              st_r   <= ST_IDLE;
            end
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // result capture: last code of each channel's averaging run
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 4; i++)
        res_r[i] <= 12'h000;
    end
    else if (st_r == ST_WAIT && cif.done && avg_left_r <= 5'h01)
      res_r[chan_r] <= cif.code;
  end

  // done flag: set at end wins over clear by new start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done_r <= 1'b0;
    else if (st_r == ST_WAIT && cif.done && avg_left_r <= 5'h01
             && !(scan && chan_r != 2'h3))
      done_r <= 1'b1;
    else if (start_r)
      done_r <= 1'b0;
  end

  assign cif.start    = (st_r == ST_CONV);
  assign cif.chan     = chan_r;
  assign cif.conv_cyc = conv_len(res_f);
  // divider only while a battery channel is converting
  assign divider_on   = (st_r == ST_CONV || st_r == ST_WAIT) && !chan_r[1];
  assign mux_sel      = chan_r;

  basseq_conv basseq_conv_inst
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .cv          (cif.conv),
    .sample_code (sample_code)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_div_off;
    @(posedge hclk) disable iff (!hresetn) (st_r == ST_IDLE) |-> !divider_on;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider on while idle");

  property p_div_aux;
    @(posedge hclk) disable iff (!hresetn) chan_r[1] |-> !divider_on;
  endproperty
  a_div_aux: assert property (p_div_aux) else $error("divider on for aux");

  property p_pre_len;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == ST_IDLE && start_r && !scan) |=> (st_r == ST_PRE) [*8];
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("reading overhead too short");

  property p_scan_first;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == ST_IDLE && start_r && scan) |=> (chan_r == 2'h0);
  endproperty
  a_scan_first: assert property (p_scan_first) else $error("scan not at channel 0");

  property p_scan_end;
    @(posedge hclk) disable iff (!hresetn)
      ($fell(busy_r) && scan) |-> (chan_r == 2'h3);
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan ended early");

  property p_res_upd;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == ST_WAIT && cif.done && avg_left_r == 5'h01)
        |=> (res_r[$past(chan_r)] == $past(cif.code));
  endproperty
  a_res_upd: assert property (p_res_upd) else $error("result not stored");

  property p_done_set;
    @(posedge hclk) disable iff (!hresetn) $fell(busy_r) |-> done_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done missing at end");

  property p_one_start;
    @(posedge hclk) disable iff (!hresetn) start_r |=> !start_r;
  endproperty
  a_one_start: assert property (p_one_start) else $error("start not a pulse");
endmodule

// *** verif/basseq_afe_model.sv ***
module basseq_afe_model
(
  // clock
  input  wire logic         hclk,
  // channel levels, batteries at full scale in 14 bits
  input  wire logic [13:0]  level [4],
  // converter side
  input  wire logic         divider_on,
  input  wire logic [1:0]   mux_sel,
  output logic      [11:0]  sample_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] junk_r;
  // changing pattern stands in for a battery pin with its divider off
  always @(posedge hclk)
  begin
    junk_r <= (junk_r === 12'hXXX) ? 12'hA5A : ~junk_r + 12'h001;
  end
  // quarter scale only while the divider is on
  always_comb
  begin
    if (mux_sel[1])
      sample_code = level[mux_sel][11:0];
    else if (divider_on)
      sample_code = level[mux_sel][13:2];
    else
      sample_code = junk_r;
  end
endmodule

// *** verif/basseq_top_test.sv ***
module basseq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        divider_on;
  logic [1:0]  mux_sel;
  logic [11:0] sample_code;
  logic [13:0] level [4];
  logic [11:0] exp_res [4];
  int          exp_q [$];
  int          bad_count;
  int          tests_run;
  int          seed;
  int          cyc;
  int          div_cyc;
  int          side_cyc;

  basseq_top basseq_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_code(sample_code),
    .divider_on(divider_on), .mux_sel(mux_sel));
  basseq_afe_model basseq_afe_model_inst (.hclk(hclk), .level(level),
    .divider_on(divider_on), .mux_sel(mux_sel), .sample_code(sample_code));

  // clock and cycle count, divider watch
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // counted on the falling edge, clear of the rising-edge races
  always @(negedge hclk)
  begin
    cyc++;
    if (divider_on === 1'b1)
      div_cyc++;
    if (divider_on === 1'b1 && mux_sel[1] !== 1'b0)
      side_cyc++;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single ahb transfer, held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    cmp("hresp", 32'h0, 32'(hresp));
  endtask

  // one conversion run against the reference model
  task automatic run(input int fn, input int ai, input int ri);
    int avg, bits, n, t, i;
    logic [31:0] r, ctl;
    avg = (ai == 0) ? 1 : (2 << ai);
    bits = (ri == 0) ? 12 : (ri == 1) ? 8 : 10;
    n = (fn == 4) ? 4 : 1;
    for (i = 0; i < 4; i++)
      level[i] <= 14'($random(seed));
    div_cyc = 0;
    side_cyc = 0;
    ctl = {24'h0, 1'b1, 2'(ri), 2'(ai), 3'(fn)};
    ahb(1'b1, basseq_pkg::CTRL_OFS, ctl, r);
    t = cyc;
    r = 32'h0;
    while (r[0] !== 1'b1 && cyc - t < 40000)
      ahb(1'b0, basseq_pkg::STATUS_OFS, 32'h0, r);
    t = cyc - t;
    n = ((fn == 4) ? basseq_pkg::SCAN_CYC : basseq_pkg::FIXED_CYC) + basseq_pkg::REF_CYC
        + n * avg * (bits * basseq_pkg::CONV_DIV + basseq_pkg::PER_CYC);
    cmp("time_ok", 32'h1, 32'(t >= n && t <= n + 8));
    cmp("busy", 32'h0, 32'(r[1]));
    ahb(1'b0, basseq_pkg::CTRL_OFS, 32'h0, r);
    cmp("ctrl", ctl & 32'h7F, r);
    for (i = 0; i < 4; i++)
    begin
      if (fn == 4 || fn == i)
        exp_res[i] = (i < 2) ? level[i][13:2] : level[i][11:0];
      exp_q.push_back(int'(exp_res[i]));
      ahb(1'b0, 8'(basseq_pkg::RESULT0_OFS + 4 * i), 32'h0, r);
      cmp("result", 32'(exp_q.pop_front()), r);
    end
    cmp("div_used", 32'(fn == 4 || fn < 2), 32'(div_cyc > 0));
    cmp("div_aux", 32'h0, 32'(side_cyc));
    cmp("div_idle", 32'h0, 32'(divider_on));
    $display("test fn %0d avg %0d bits %0d took %0d of %0d", fn, avg, bits, t, n);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    logic [31:0] r;
    seed = 29;
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    for (int i = 0; i < 4; i++)
    begin
      level[i] = 14'h0;
      exp_res[i] = 12'h000;
    end
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, basseq_pkg::STATUS_OFS, 32'h0, r);
    cmp("status_rst", 32'h0, r);
    ahb(1'b0, basseq_pkg::CTRL_OFS, 32'h0, r);
    cmp("ctrl_rst", 32'(basseq_pkg::CTRL_RST), r);
    for (int f = 0; f < 5; f++)
      run(f, {$random(seed)} % 2, {$random(seed)} % 3);
    run(4, 0, 1);
    run(0, 3, 1);
    run(4, 0, 1);
    ahb(1'b0, 8'h40, 32'h0, r);
    cmp("unmapped", 32'h0, r);
    stop_test;
  end

  // watchdog
  initial
  begin
    #500000;
    bad_count++;
    stop_test;
  end
endmodule
